// ---- hdl/pmdc_ctrl.sv ----
// Power mode controller: maps four modes onto domain and clock enables.
// Assumes AHB-Lite single word transfers and an always-on clock.
// How it works
// - A write to the mode register in Active or Modem-sleep selects one of four fixed modes, each a preset set of domain enables.
// - Active mode turns on the processor, radio and every peripheral domain.
// - Modem-sleep keeps the processor powered and running, optionally at a reduced clock.
// - With wireless logic on and radio off in a sleep mode, the radio is pulsed on periodically.
// - Light-sleep halts the processor, and a config bit chooses whether it stays powered.
// - Light-sleep issues periodic timer ticks to the low-power peripherals.
// - Any enabled wake source (modem, timer, external) ends Light-sleep.
// - Light-sleep powers off the peripheral groups selected in configuration.
// - Deep-sleep removes main digital, processor, peripherals and wireless power.
// - Before Deep-sleep, a save request holds connection state into low-power memory until it is done.
// - Light and Deep-sleep stop the fast RC, crystal, PLL, radio and wireless logic; Modem-sleep keeps clocks.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module pmdc_ctrl
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire pmdc_pkg::pmdc_ahb_type ahb_req,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic wake_modem,
   input wire logic wake_rtc,
   input wire logic wake_ext,
   input wire logic save_done,
   output pmdc_pkg::pmdc_dom_type dom
);
   pmdc_pkg::pmdc_state_all_type s_q;
   pmdc_pkg::pmdc_state_all_type s_d;
   logic [2:0] wake_hit;
   logic addr_take;

   // ----------------------------------------
   // Bus outputs
   // ----------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign dom = s_q.dom;
   assign addr_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
   // Enabled wake sources
   assign wake_hit = {wake_ext, wake_rtc, wake_modem} & s_q.wake_en;

   // Domain preset per state
   function automatic pmdc_pkg::pmdc_dom_type preset(input pmdc_pkg::pmdc_state_type st,
      input logic [7:0] cfg);
      pmdc_pkg::pmdc_dom_type d;
      d = '0;
      case (st)
         pmdc_pkg::ST_ACTIVE:
         begin
            d.cpu_power = 1'b1;
            d.cpu_run = 1'b1;
            d.main_digital = 1'b1;
            d.periph_power = '1;
            d.wireless_digital = 1'b1;
            d.rf = 1'b1;
            d.fast_rc_oscillator_clock = 1'b1;
            d.crystal_reference_clock = 1'b1;
            d.pll = 1'b1;
         end
         pmdc_pkg::ST_MODEM:
         begin
            d.cpu_power = 1'b1;
            d.cpu_run = 1'b1;
            d.cpu_slow = cfg[pmdc_pkg::CFG_SLOW_CPU_BIT];
            d.main_digital = 1'b1;
            d.periph_power = '1;
            d.wireless_digital = 1'b1;
            d.fast_rc_oscillator_clock = 1'b1;
            d.crystal_reference_clock = 1'b1;
            d.pll = 1'b1;
         end
         pmdc_pkg::ST_LIGHT:
         begin
            d.cpu_power = cfg[pmdc_pkg::CFG_CPU_KEEP_BIT];
            d.main_digital = 1'b1;
            d.periph_power = ~cfg[pmdc_pkg::CFG_PERIPH_OFF_LSB +: pmdc_pkg::PERIPH_GROUPS];
            d.wireless_digital = 1'b0;
         end
         pmdc_pkg::ST_WAKE:
         begin
            d.cpu_power = 1'b1;
            d.main_digital = 1'b1;
            d.periph_power = '1;
            d.wireless_digital = 1'b1;
            d.rf = 1'b1;
            d.fast_rc_oscillator_clock = 1'b1;
            d.crystal_reference_clock = 1'b1;
            d.pll = 1'b1;
         end
         pmdc_pkg::ST_SAVE:
         begin
            d.cpu_power = 1'b1;
            d.main_digital = 1'b1;
            d.periph_power = '1;
            d.wireless_digital = 1'b1;
            d.fast_rc_oscillator_clock = 1'b1;
            d.crystal_reference_clock = 1'b1;
            d.pll = 1'b1;
            d.save_req = 1'b1;
         end
         pmdc_pkg::ST_DEEP:
         begin
            d = '0;
         end
         default:
         begin
            d = '0;
         end
      endcase
      return d;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.mode_go = 1'b0;
      s_d.wake_seen = wake_hit;
      // Bus data phase
      if (s_q.dph_valid && s_q.dph_write)
      begin
         case (s_q.dph_addr)
            pmdc_pkg::REG_MODE:
            begin
               s_d.req_mode = hwdata[1:0];
               s_d.mode_go = 1'b1;
            end
            pmdc_pkg::REG_CFG: s_d.cfg = hwdata[7:0];
            pmdc_pkg::REG_WAKE_EN: s_d.wake_en = hwdata[2:0];
            pmdc_pkg::REG_RF_PERIOD: s_d.rf_period = hwdata[15:0];
            pmdc_pkg::REG_LP_PERIOD: s_d.lp_period = hwdata[15:0];
            default: s_d.req_mode = s_q.req_mode;
         endcase
      end
      // Address phase capture and read data
      s_d.dph_valid = addr_take;
      s_d.dph_write = ahb_req.hwrite;
      s_d.dph_addr = ahb_req.haddr[7:0];
      if (addr_take && !ahb_req.hwrite)
      begin
         case (ahb_req.haddr[7:0])
            pmdc_pkg::REG_MODE: s_d.rdata = {30'h0000_0000, s_q.req_mode};
            pmdc_pkg::REG_CFG: s_d.rdata = {24'h00_0000, s_q.cfg};
            pmdc_pkg::REG_STATUS: s_d.rdata = {13'h0000, s_q.wake_seen, 4'h0, 12'(s_q.dom)};
            pmdc_pkg::REG_WAKE_EN: s_d.rdata = {29'h0000_0000, s_q.wake_en};
            pmdc_pkg::REG_RF_PERIOD: s_d.rdata = {16'h0000, s_q.rf_period};
            pmdc_pkg::REG_LP_PERIOD: s_d.rdata = {16'h0000, s_q.lp_period};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Mode state machine
      case (s_q.state)
         pmdc_pkg::ST_ACTIVE, pmdc_pkg::ST_MODEM:
         begin
            if (s_q.mode_go)
            begin
               case (s_q.req_mode)
                  pmdc_pkg::MODE_MODEM: s_d.state = pmdc_pkg::ST_MODEM;
                  pmdc_pkg::MODE_LIGHT: s_d.state = pmdc_pkg::ST_LIGHT;
                  pmdc_pkg::MODE_DEEP: s_d.state = pmdc_pkg::ST_SAVE;
                  default: s_d.state = pmdc_pkg::ST_ACTIVE;
               endcase
            end
         end
         pmdc_pkg::ST_LIGHT, pmdc_pkg::ST_DEEP:
         begin
            if (|wake_hit)
            begin
               s_d.state = pmdc_pkg::ST_WAKE;
               s_d.settle_cnt = 8'(pmdc_pkg::SETTLE_CYCLES);
               s_d.req_mode = pmdc_pkg::MODE_ACTIVE;
            end
         end
         pmdc_pkg::ST_SAVE:
         begin
            if (save_done)
            begin
               s_d.state = pmdc_pkg::ST_DEEP;
            end
         end
         pmdc_pkg::ST_WAKE:
         begin
            if (s_q.settle_cnt == 8'h00)
            begin
               s_d.state = pmdc_pkg::ST_ACTIVE;
            end
            else
            begin
               s_d.settle_cnt = s_q.settle_cnt - 8'h01;
            end
         end
         default: s_d.state = pmdc_pkg::ST_ACTIVE;
      endcase
      s_d.dom = preset(s_d.state, s_d.cfg);
      // Periodic radio keep-alive while wireless logic is powered outside Active
      if (s_d.dom.wireless_digital && (s_d.state != pmdc_pkg::ST_ACTIVE))
      begin
         if (s_q.rf_on_cnt != 8'h00)
         begin
            s_d.rf_on_cnt = s_q.rf_on_cnt - 8'h01;
            s_d.dom.rf = 1'b1;
         end
         else if (s_q.rf_cnt >= s_q.rf_period)
         begin
            s_d.rf_cnt = 16'h0000;
            s_d.rf_on_cnt = 8'(pmdc_pkg::RF_ON_CYCLES);
            s_d.dom.rf = 1'b1;
         end
         else
         begin
            s_d.rf_cnt = s_q.rf_cnt + 16'h0001;
         end
      end
      else
      begin
         s_d.rf_cnt = 16'h0000;
         s_d.rf_on_cnt = 8'h00;
      end
      // Low-power peripheral tick in Light-sleep
      if (s_d.state == pmdc_pkg::ST_LIGHT)
      begin
         if (s_q.lp_cnt >= s_q.lp_period)
         begin
            s_d.lp_cnt = 16'h0000;
            s_d.dom.lp_periph_tick = 1'b1;
         end
         else
         begin
            s_d.lp_cnt = s_q.lp_cnt + 16'h0001;
         end
      end
      else
      begin
         s_d.lp_cnt = 16'h0000;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.state <= pmdc_pkg::ST_ACTIVE;
         s_q.cfg <= pmdc_pkg::CFG_RESET;
         s_q.wake_en <= pmdc_pkg::WAKE_EN_RESET;
         s_q.rf_period <= pmdc_pkg::RF_PERIOD_RESET;
         s_q.lp_period <= pmdc_pkg::LP_PERIOD_RESET;
         s_q.dom <= preset(pmdc_pkg::ST_ACTIVE, pmdc_pkg::CFG_RESET); // Active domains from reset
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !clk_en);

   chk_active_all_on: assert property (s_q.state == pmdc_pkg::ST_ACTIVE |-> dom.cpu_run && dom.rf && dom.pll)
      else $error("active mode domain off");
   chk_modem_cpu_on: assert property (s_q.state == pmdc_pkg::ST_MODEM |-> dom.cpu_power && dom.cpu_run)
      else $error("modem sleep cpu off");
   chk_light_cpu_halt: assert property (s_q.state == pmdc_pkg::ST_LIGHT |-> !dom.cpu_run)
      else $error("cpu runs in light sleep");
   chk_light_clocks_off: assert property (s_q.state == pmdc_pkg::ST_LIGHT |->
      !dom.pll && !dom.crystal_reference_clock && !dom.fast_rc_oscillator_clock)
      else $error("clock on in light sleep");
   chk_deep_all_off: assert property (s_q.state == pmdc_pkg::ST_DEEP |-> dom.main_digital == 1'b0)
      else $error("main domain on in deep sleep");
   chk_deep_after_save: assert property ($rose(s_q.state == pmdc_pkg::ST_DEEP) |->
      $past(s_q.state) == pmdc_pkg::ST_SAVE)
      else $error("deep sleep without save");
   chk_light_wake: assert property (s_q.state == pmdc_pkg::ST_LIGHT && |wake_hit |=>
      s_q.state == pmdc_pkg::ST_WAKE)
      else $error("wake source ignored");
   sequence wake_settle;
      s_q.state == pmdc_pkg::ST_WAKE && !dom.cpu_run;
   endsequence
   chk_wake_cpu_hold: assert property ($rose(s_q.state == pmdc_pkg::ST_WAKE) |->
      wake_settle ##1 (s_q.state == pmdc_pkg::ST_WAKE) [*8])
      else $error("cpu released before settle");
endmodule

// ---- hdl/pmdc_pkg.sv ----
// Package for the power mode and domain controller.
// Assumes one 20 MHz clock and an AHB-Lite slave port.
package pmdc_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_WAKE_EN = 8'h0C;
   localparam logic [7:0] REG_RF_PERIOD = 8'h10;
   localparam logic [7:0] REG_LP_PERIOD = 8'h14;
   // ----------------------------------------
   // Mode codes and field positions
   // ----------------------------------------
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_MODEM = 2'h1;
   localparam logic [1:0] MODE_LIGHT = 2'h2;
   localparam logic [1:0] MODE_DEEP = 2'h3;
   localparam int CFG_CPU_KEEP_BIT = 0;
   localparam int CFG_WIRELESS_KEEP_BIT = 1;
   localparam int CFG_SLOW_CPU_BIT = 2;
   localparam int CFG_PERIPH_OFF_LSB = 4;
   localparam int PERIPH_GROUPS = 4;
   localparam int WAKE_MODEM_BIT = 0;
   localparam int WAKE_RTC_BIT = 1;
   localparam int WAKE_EXT_BIT = 2;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [2:0] WAKE_EN_RESET = 3'h7;
   localparam logic [15:0] RF_PERIOD_RESET = 16'h03E8;
   localparam logic [15:0] LP_PERIOD_RESET = 16'h07D0;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RF_ON_TIME_NS = 500;
   localparam int RF_ON_CYCLES = (RF_ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum {ST_ACTIVE, ST_MODEM, ST_LIGHT, ST_SAVE, ST_DEEP, ST_WAKE} pmdc_state_type;

   // Domain and clock enables
   typedef struct packed {
      logic cpu_power;
      logic cpu_run;
      logic cpu_slow;
      logic main_digital;
      logic [PERIPH_GROUPS-1:0] periph_power;
      logic wireless_digital;
      logic rf;
      logic fast_rc_oscillator_clock;
      logic crystal_reference_clock;
      logic pll;
      logic lp_periph_tick;
      logic save_req;
   } pmdc_dom_type;

   // AHB-Lite request
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } pmdc_ahb_type;

   // Whole module state
   typedef struct packed {
      pmdc_state_type state;
      logic [1:0] req_mode;
      logic [7:0] cfg;
      logic [2:0] wake_en;
      logic [15:0] rf_period;
      logic [15:0] lp_period;
      logic [15:0] rf_cnt;
      logic [15:0] lp_cnt;
      logic [7:0] rf_on_cnt;
      logic [7:0] settle_cnt;
      logic mode_go;
      logic [2:0] wake_seen;
      logic dph_valid;
      logic dph_write;
      logic [7:0] dph_addr;
      logic [31:0] rdata;
      pmdc_dom_type dom;
   } pmdc_state_all_type;
endpackage

// ---- tb/pmdc_tb.sv ----
// Self-checking bench for the power mode controller.
// Assumes pmdc_pkg and pmdc_ctrl are compiled before this file.
`timescale 1ns/1ps
module tb;
   // ------------------------------
   // Signals and bookkeeping
   // ------------------------------
   localparam int DW = $bits(pmdc_pkg::pmdc_dom_type);
   localparam int B_RF = 5;
   localparam int B_TICK = 1;
   localparam int B_RUN = 13;
   localparam int B_XTAL = 3;
   typedef struct packed {logic [1:0] kind; logic [31:0] exp; logic [31:0] mask;} pmdc_note_type;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [2:0] wake = 3'h0;
   logic save_done = 1'b0;
   pmdc_pkg::pmdc_dom_type dom;
   pmdc_pkg::pmdc_ahb_type ahb;
   logic [DW-1:0] domv;
   logic dph = 1'b0;
   logic dom_req = 1'b0;
   logic meas_req = 1'b0;
   logic [31:0] meas = 32'h0000_0000;
   logic [31:0] got;
   logic [31:0] lfsr = 32'h0001_7187;
   logic [7:0] c;
   pmdc_note_type q[$];
   pmdc_note_type nt;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   int t;

   assign ahb = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2, hready: hreadyout};
   assign domv = dom;

   pmdc_ctrl u_dut
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .ahb_req(ahb),
      .hwdata(hwdata),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wake_modem(wake[0]),
      .wake_rtc(wake[1]),
      .wake_ext(wake[2]),
      .save_done(save_done),
      .dom(dom)
   );

   // Free running clock
   initial
   begin
      forever #25 clk = ~clk;
   end

   // ------------------------------
   // Monitor and timeout
   // ------------------------------
   always @(posedge clk)
   begin
      dph <= hsel && htrans[1] && hreadyout && !hwrite;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end

   // Oldest note against the result that shows
   always @(negedge clk)
   begin
      // Slave must answer OKAY in every read data phase
      if (dph && hresp !== 1'b0)
      begin
         n_fail++;
         $display("MISMATCH at %0t: error response", $time);
      end
      if (dph || dom_req || meas_req)
      begin
         n_checks++;
         if (q.size() > 0)
            nt = q.pop_front();
         else
            nt = '{2'h3, 32'h0000_0000, 32'h0000_0000};
         got = nt.kind == 2'h0 ? hrdata : (nt.kind == 2'h1 ? 32'(domv) : meas);
         if (nt.kind == 2'h3 || (got & nt.mask) !== (nt.exp & nt.mask))
         begin
            n_fail++;
            $display("MISMATCH at %0t: kind %0d got %h exp %h", $time, nt.kind, got, nt.exp);
         end
      end
   end

   // ------------------------------
   // Driver tasks
   // ------------------------------
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Next value of the stimulus shift register
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // One single word transfer; d is write data or expected read data
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      if (!w)
         q.push_back('{2'h0, d, m});
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
   endtask

   task automatic chk_raw(input logic [DW-1:0] e, input logic [DW-1:0] m);
      q.push_back('{2'h1, 32'(e), 32'(m)});
      dom_req <= 1'b1;
      @(posedge clk);
      dom_req <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk_val(input int e, input int v);
      q.push_back('{2'h2, 32'(e), 32'hFFFF_FFFF});
      meas <= 32'(v);
      meas_req <= 1'b1;
      @(posedge clk);
      meas_req <= 1'b0;
      @(posedge clk);
   endtask

   // Expected domain preset of a mode under configuration cf
   task automatic chk_mode(input logic [1:0] md, input logic [7:0] cf);
      pmdc_pkg::pmdc_dom_type e;
      pmdc_pkg::pmdc_dom_type m;
      logic on;
      on = md < 2'h2;
      e = '0;
      m = '1;
      m.lp_periph_tick = 1'b0;
      m.cpu_slow = on;
      m.rf = md != 2'h1;
      e.cpu_power = on || (md == 2'h2 && cf[0]);
      e.cpu_run = on;
      e.cpu_slow = md == 2'h1 && cf[2];
      e.main_digital = md != 2'h3;
      e.periph_power = md == 2'h3 ? 4'h0 : (md == 2'h2 ? ~cf[7:4] : 4'hF);
      e.wireless_digital = on;
      e.rf = md == 2'h0;
      e.fast_rc_oscillator_clock = on;
      e.crystal_reference_clock = on;
      e.pll = on;
      chk_raw(e, m);
   endtask

   // Cycles while a domain bit stays at lvl, sampled on falling edges
   task automatic span(input int b, input logic lvl, output int k);
      k = 0;
      while (domv[b] === lvl && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
   endtask

   task automatic wake_up(input logic [2:0] src, output int k);
      wake <= src;
      @(negedge clk);
      span(B_XTAL, 1'b0, k);
      span(B_RUN, 1'b0, k);
      @(posedge clk);
      wake <= 3'h0;
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk_mode(2'h0, pmdc_pkg::CFG_RESET);
      clk_en <= 1'b1;
      @(posedge clk);
      chk_mode(2'h0, 8'h00);
      bus(1'b0, pmdc_pkg::REG_CFG, {24'h00_0000, pmdc_pkg::CFG_RESET}, 32'h0000_00FF);
      bus(1'b0, pmdc_pkg::REG_WAKE_EN, {29'h0000_0000, pmdc_pkg::WAKE_EN_RESET}, 32'h0000_0007);
      bus(1'b0, pmdc_pkg::REG_RF_PERIOD, {16'h0000, pmdc_pkg::RF_PERIOD_RESET}, 32'h0000_FFFF);
      bus(1'b0, pmdc_pkg::REG_LP_PERIOD, {16'h0000, pmdc_pkg::LP_PERIOD_RESET}, 32'h0000_FFFF);
      bus(1'b0, pmdc_pkg::REG_STATUS, 32'h0000_0FFC, 32'h0007_0FFF);
      bus(1'b1, 8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
      bus(1'b0, 8'h18, 32'h0000_0000, 32'hFFFF_FFFF);
      bus(1'b1, pmdc_pkg::REG_RF_PERIOD, 32'h0000_001E, 32'h0000_0000);
      bus(1'b1, pmdc_pkg::REG_LP_PERIOD, 32'h0000_0014, 32'h0000_0000);
      lfsr = lfsr_next(lfsr);
      c = (lfsr[7:0] & 8'hF1) | 8'h04;
      bus(1'b1, pmdc_pkg::REG_CFG, {24'h00_0000, c}, 32'h0000_0000);
      bus(1'b0, pmdc_pkg::REG_CFG, {24'h00_0000, c}, 32'h0000_00F5);
      // Modem-sleep and its radio pulses
      bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0001, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk_mode(2'h1, c);
      @(negedge clk);
      span(B_RF, 1'b0, n);
      span(B_RF, 1'b1, n);
      span(B_RF, 1'b0, t);
      @(posedge clk);
      chk_val(pmdc_pkg::RF_ON_CYCLES + 1, n);
      chk_val(1, int'(t > 0 && t <= 31));
      // Light-sleep, refused mode change, timer ticks
      bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0002, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk_mode(2'h2, c);
      bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0003, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk_mode(2'h2, c);
      t = 0;
      repeat (63)
      begin
         @(negedge clk);
         t += int'(domv[B_TICK] === 1'b1);
      end
      @(posedge clk);
      chk_val(3, t);
      // Every wake source, first masked then enabled
      for (int i = 0; i < 3; i++)
      begin
         if (i > 0)
         begin
            c[0] = ~c[0];
            bus(1'b1, pmdc_pkg::REG_CFG, {24'h00_0000, c}, 32'h0000_0000);
            bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0002, 32'h0000_0000);
         end
         bus(1'b1, pmdc_pkg::REG_WAKE_EN, 32'(~(3'h1 << i)), 32'h0000_0000);
         wake <= 3'h1 << i;
         repeat (10) @(posedge clk);
         chk_mode(2'h2, c);
         bus(1'b1, pmdc_pkg::REG_WAKE_EN, 32'h0000_0007, 32'h0000_0000);
         wake_up(3'h1 << i, n);
         chk_val(pmdc_pkg::SETTLE_CYCLES + 1, n);
         chk_mode(2'h0, c);
      end
      // Deep-sleep with a slow state save, then timer wake
      bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0003, 32'h0000_0000);
      lfsr = lfsr_next(lfsr);
      repeat (5 + lfsr[3:0]) @(posedge clk);
      chk_raw(DW'(1), DW'(1));
      save_done <= 1'b1;
      repeat (3) @(posedge clk);
      save_done <= 1'b0;
      chk_mode(2'h3, c);
      wake_up(3'h2, n);
      chk_val(pmdc_pkg::SETTLE_CYCLES + 1, n);
      chk_mode(2'h0, c);
      // Modem-sleep back to Active by a mode write
      bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0001, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk_mode(2'h1, c);
      bus(1'b1, pmdc_pkg::REG_MODE, 32'h0000_0000, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk_mode(2'h0, c);
      stop_test();
   end
endmodule
